// *** mct_pkg.sv ***
`default_nettype none
package mct_pkg;
    // ****************************************************************
    // Direct byte locations
    // ****************************************************************
    localparam logic [11:0] ADDR_COUNT_HIGH  = 12'hFA0;
    localparam logic [11:0] ADDR_COUNT_LOW   = 12'hFA1;
    localparam logic [11:0] ADDR_RELOAD_HIGH = 12'hFA2;
    localparam logic [11:0] ADDR_RELOAD_LOW  = 12'hFA3;
    localparam logic [11:0] ADDR_SUBADDRESS  = 12'hFA4;
    localparam logic [11:0] ADDR_PORT_ZERO   = 12'hFA5;
    localparam logic [11:0] ADDR_PORT_ONE    = 12'hFA6;
    localparam logic [11:0] ADDR_PORT_TWO    = 12'hFA7;

    // ****************************************************************
    // Subaddresses
    // ****************************************************************
    localparam int          SUB_W            = 3;
    localparam logic [2:0]  SUB_CONTROL      = 3'h0;
    localparam logic [2:0]  SUB_STATUS       = 3'h1;
    localparam logic [2:0]  SUB_CHANNEL_A    = 3'h2;
    localparam logic [2:0]  SUB_CHANNEL_D    = 3'h5;
    localparam int          CHANNELS         = 4;

    // ****************************************************************
    // Field positions and masks
    // ****************************************************************
    localparam int          CTL0_CYCLE_DONE  = 7;
    localparam int          CTL0_CHAN_STATUS = 6;
    localparam logic [7:0]  CTL0_WRITE_MASK  = 8'h27;
    localparam int          CTL1_RUN_ENABLE  = 7;
    localparam int          CTL1_MODE_UPDOWN = 5;
    localparam int          CHCTL_IMMEDIATE  = 5;
    localparam logic [7:0]  STATUS1_MASK     = 8'h0F;

    // ****************************************************************
    // Reset values and the count step
    // ****************************************************************
    localparam logic [15:0] COUNT_RESET      = 16'h0000;
    localparam logic [15:0] RELOAD_RESET     = 16'hFFFF;
    localparam logic [7:0]  BYTE_RESET       = 8'h00;
    localparam logic [15:0] COUNT_ONE        = 16'h0001;
endpackage
`default_nettype wire

// *** compare_channel.sv ***
`timescale 1ns/1ns
`default_nettype none
// ********************************************************************
// One capture/compare channel: written bytes and the active value
// ********************************************************************
module compare_channel (
    input  wire logic        clk,          // System clock
    input  wire logic        rst,          // Synchronous reset
    input  wire logic        write_high,   // Write compare high byte
    input  wire logic        write_low,    // Write compare low byte
    input  wire logic [7:0]  wdata,        // Write data
    input  wire logic        immediate,    // Immediate-update bit
    input  wire logic        apply,        // End of cycle or timer disabled
    output logic      [15:0] written_reg,  // Value as software wrote it
    output logic      [15:0] active_reg    // Value the compare uses
);
    logic [15:0] written_next;
    logic        pending_reg;
    logic        pending_next;
    logic        any_write;

    assign any_write    = write_high | write_low;
    assign written_next = {write_high ? wdata : written_reg[15:8],
                           write_low  ? wdata : written_reg[7:0]};
    assign pending_next = (pending_reg | any_write) & ~apply & ~immediate;

    always_ff @(posedge clk) begin
        if (rst) begin
            written_reg <= mct_pkg::COUNT_RESET;
            active_reg  <= mct_pkg::COUNT_RESET;
            pending_reg <= 1'b0;
        end else begin
            written_reg <= written_next;
            pending_reg <= pending_next;
            if (any_write && immediate) begin
                active_reg <= written_next;
            end else if (apply && (pending_reg || any_write)) begin
                active_reg <= written_next;
            end
        end
    end
endmodule
`default_nettype wire

// *** multichannel_timer_reg_access.sv ***
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module multichannel_timer_reg_access (
    input  wire logic        clk,                 // System clock, 100 MHz
    input  wire logic        rst,                 // Synchronous reset
    input  wire logic [11:0] addr,                // Register byte address
    input  wire logic [7:0]  wdata,               // Write data
    input  wire logic        wr,                  // Write strobe
    input  wire logic        rd,                  // Read strobe
    input  wire logic        count_tick,          // Clock source active
    input  wire logic [3:0]  channel_event,       // Channel event pulses
    output logic      [7:0]  rdata,               // Read data, next cycle
    output logic      [15:0] count_value,         // Live count
    output logic      [15:0] reload_value,        // Active reload
    output logic      [7:0]  timer_control_zero,  // Control zero
    output logic      [7:0]  timer_control_one,   // Control one
    output logic      [31:0] channel_control,     // Channel controls D..A
    output logic      [63:0] compare_value,       // Active compares D..A
    output logic             cycle_end            // End of count cycle
);
    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic       wr_cnt_hi;
    logic       wr_cnt_lo;
    logic       wr_rld_hi;
    logic       wr_rld_lo;
    logic       wr_sub;
    logic       wr_p0;
    logic       wr_p1;
    logic       wr_p2;
    logic       rd_cnt_hi;
    logic [2:0] sub;
    logic       sub_chan;
    logic [1:0] chan_idx;
    logic [2:0] chan_off;

    assign wr_cnt_hi = wr && addr == mct_pkg::ADDR_COUNT_HIGH;
    assign wr_cnt_lo = wr && addr == mct_pkg::ADDR_COUNT_LOW;
    assign wr_rld_hi = wr && addr == mct_pkg::ADDR_RELOAD_HIGH;
    assign wr_rld_lo = wr && addr == mct_pkg::ADDR_RELOAD_LOW;
    assign wr_sub    = wr && addr == mct_pkg::ADDR_SUBADDRESS;
    assign wr_p0     = wr && addr == mct_pkg::ADDR_PORT_ZERO;
    assign wr_p1     = wr && addr == mct_pkg::ADDR_PORT_ONE;
    assign wr_p2     = wr && addr == mct_pkg::ADDR_PORT_TWO;
    assign rd_cnt_hi = rd && addr == mct_pkg::ADDR_COUNT_HIGH;

    logic [7:0] subaddress_reg;
    assign sub      = subaddress_reg[mct_pkg::SUB_W-1:0];
    assign sub_chan = sub >= mct_pkg::SUB_CHANNEL_A &&
                      sub <= mct_pkg::SUB_CHANNEL_D;
    assign chan_off = sub - mct_pkg::SUB_CHANNEL_A;
    assign chan_idx = chan_off[1:0];

    // ****************************************************************
    // Control and status
    // ****************************************************************
    logic       run_enable;
    logic       updown;
    logic [7:0] status_zero_reg;
    logic [7:0] status_one_reg;
    logic [7:0] status_one_next;
    logic [7:0] ctl0_next;
    logic       done_bit;
    logic       cycle_next;
    logic [7:0] ctl0_masked;
    logic       wr_ctl0;
    logic       wr_st1;
    logic       apply;

    assign run_enable = timer_control_one[mct_pkg::CTL1_RUN_ENABLE];
    assign updown     = timer_control_one[mct_pkg::CTL1_MODE_UPDOWN];
    assign wr_ctl0    = wr_p0 && sub == mct_pkg::SUB_CONTROL;
    assign wr_st1     = wr_p1 && sub == mct_pkg::SUB_STATUS;
    assign apply      = cycle_next | ~run_enable;

    // Event set wins over a write-one clear in the same cycle
    assign status_one_next = run_enable ?
        (((status_one_reg & ~(wr_st1 ? wdata : mct_pkg::BYTE_RESET))
          | {4'h0, channel_event}) & mct_pkg::STATUS1_MASK) :
        mct_pkg::BYTE_RESET;

    assign done_bit = run_enable &&
        (cycle_next || (timer_control_zero[mct_pkg::CTL0_CYCLE_DONE] &&
         !(wr_ctl0 && wdata[mct_pkg::CTL0_CYCLE_DONE])));
    assign ctl0_masked = (wr_ctl0 ? wdata : timer_control_zero) &
                         mct_pkg::CTL0_WRITE_MASK;
    assign ctl0_next   = {done_bit, |status_one_next,
                          ctl0_masked[mct_pkg::CTL0_CHAN_STATUS-1:0]};

    // ****************************************************************
    // Counter
    // ****************************************************************
    logic        count_down_reg;
    logic        at_top;
    logic [15:0] step_value;
    logic [15:0] count_next;
    logic        down_next;
    logic        counting;

    assign counting = run_enable & count_tick;
    assign at_top   = count_value >= reload_value;
    assign cycle_next = counting && (updown ?
        (count_down_reg && count_value == mct_pkg::COUNT_ONE) : at_top);

    always_comb begin
        step_value = count_value;
        down_next  = count_down_reg;
        if (!updown) begin
            step_value = at_top ? mct_pkg::COUNT_RESET :
                         count_value + mct_pkg::COUNT_ONE;
            down_next  = 1'b0;
        end else if (count_down_reg) begin
            if (count_value == mct_pkg::COUNT_RESET) begin
                down_next = 1'b0;
            end else begin
                step_value = count_value - mct_pkg::COUNT_ONE;
                down_next  = count_value != mct_pkg::COUNT_ONE;
            end
        end else if (at_top) begin
            if (reload_value != mct_pkg::COUNT_RESET) begin
                step_value = count_value - mct_pkg::COUNT_ONE;
                down_next  = 1'b1;
            end
        end else begin
            step_value = count_value + mct_pkg::COUNT_ONE;
        end
    end

    // Disabled timer holds the count; count byte writes still load it
    assign count_next = {wr_cnt_hi ? wdata :
                         counting  ? step_value[15:8] :
                         count_value[15:8],
                         wr_cnt_lo ? wdata :
                         counting  ? step_value[7:0] :
                         count_value[7:0]};

    // ****************************************************************
    // Reload staging
    // ****************************************************************
    logic [7:0]  reload_hold_reg;
    logic [15:0] reload_stage_reg;
    logic        reload_pend_reg;

    // ****************************************************************
    // Channels
    // ****************************************************************
    logic [63:0] written_flat;
    logic [63:0] active_flat;

    genvar g;
    generate
        for (g = 0; g < mct_pkg::CHANNELS; g = g + 1) begin : gen_ch
            compare_channel u_chan (
                .clk         (clk),
                .rst         (rst),
                .write_high  (wr_p0 && sub_chan && chan_idx == g),
                .write_low   (wr_p1 && sub_chan && chan_idx == g),
                .wdata       (wdata),
                .immediate   (channel_control[8*g+mct_pkg::CHCTL_IMMEDIATE]),
                .apply       (apply),
                .written_reg (written_flat[16*g+15:16*g]),
                .active_reg  (active_flat[16*g+15:16*g])
            );
        end
    endgenerate

    // ****************************************************************
    // Read select
    // ****************************************************************
    logic [7:0]  count_latch_reg;
    logic [15:0] sel_written;
    logic [7:0]  sel_control;
    logic [7:0]  port0_data;
    logic [7:0]  port1_data;
    logic [7:0]  port2_data;
    logic [7:0]  rdata_next;

    assign sel_written = written_flat[{chan_idx, 4'h0} +: 16];
    assign sel_control = channel_control[{chan_idx, 3'h0} +: 8];

    assign port0_data = sub == mct_pkg::SUB_CONTROL ? timer_control_zero :
                        sub == mct_pkg::SUB_STATUS  ? status_zero_reg :
                        sub_chan ? sel_written[15:8] :
                        mct_pkg::BYTE_RESET;
    assign port1_data = sub == mct_pkg::SUB_CONTROL ? timer_control_one :
                        sub == mct_pkg::SUB_STATUS  ? status_one_reg :
                        sub_chan ? sel_written[7:0] :
                        mct_pkg::BYTE_RESET;
    assign port2_data = sub_chan ? sel_control :
                        mct_pkg::BYTE_RESET;

    always_comb begin
        unique case (addr)
            mct_pkg::ADDR_COUNT_HIGH:  rdata_next = count_value[15:8];
            mct_pkg::ADDR_COUNT_LOW:   rdata_next = run_enable ?
                count_latch_reg :
                count_value[7:0];
            mct_pkg::ADDR_RELOAD_HIGH: rdata_next = reload_value[15:8];
            mct_pkg::ADDR_RELOAD_LOW:  rdata_next = reload_value[7:0];
            mct_pkg::ADDR_SUBADDRESS:  rdata_next = subaddress_reg;
            mct_pkg::ADDR_PORT_ZERO:   rdata_next = port0_data;
            mct_pkg::ADDR_PORT_ONE:    rdata_next = port1_data;
            mct_pkg::ADDR_PORT_TWO:    rdata_next = port2_data;
            default:                   rdata_next = mct_pkg::BYTE_RESET;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata              <= mct_pkg::BYTE_RESET;
            count_value        <= mct_pkg::COUNT_RESET;
            count_down_reg     <= 1'b0;
            count_latch_reg    <= mct_pkg::BYTE_RESET;
            cycle_end          <= 1'b0;
            subaddress_reg     <= mct_pkg::BYTE_RESET;
            timer_control_zero <= mct_pkg::BYTE_RESET;
            timer_control_one  <= mct_pkg::BYTE_RESET;
            status_zero_reg    <= mct_pkg::BYTE_RESET;
            status_one_reg     <= mct_pkg::BYTE_RESET;
            channel_control    <= '0;
            compare_value      <= '0;
        end else begin
            rdata          <= rd ? rdata_next : mct_pkg::BYTE_RESET;
            count_value    <= count_next;
            count_down_reg <= counting ? down_next : count_down_reg;
            cycle_end      <= cycle_next;
            compare_value  <= active_flat;
            if (rd_cnt_hi && run_enable) begin
                count_latch_reg <= count_value[7:0];
            end
            if (wr_sub) begin
                subaddress_reg <= wdata;
            end
            timer_control_zero <= ctl0_next;
            status_one_reg     <= status_one_next;
            if (wr_p1 && sub == mct_pkg::SUB_CONTROL) begin
                timer_control_one <= wdata;
            end
            if (wr_p0 && sub == mct_pkg::SUB_STATUS) begin
                status_zero_reg <= wdata;
            end
            if (wr_p2 && sub_chan) begin
                channel_control[{chan_idx, 3'h0} +: 8] <= wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reload_hold_reg  <= mct_pkg::RELOAD_RESET[15:8];
            reload_stage_reg <= mct_pkg::RELOAD_RESET;
            reload_pend_reg  <= 1'b0;
            reload_value     <= mct_pkg::RELOAD_RESET;
        end else begin
            if (wr_rld_hi) begin
                reload_hold_reg <= wdata;
            end
            if (wr_rld_lo && !run_enable) begin
                reload_value    <= {reload_hold_reg, wdata};
                reload_pend_reg <= 1'b0;
            end else if (wr_rld_lo) begin
                reload_stage_reg <= {reload_hold_reg, wdata};
                reload_pend_reg  <= 1'b1;
            end else if (reload_pend_reg && apply) begin
                reload_value    <= reload_stage_reg;
                reload_pend_reg <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** reg_access_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module reg_access_monitor (
    input wire logic        clk,                // System clock
    input wire logic        rst,                // Synchronous reset
    input wire logic [11:0] addr,               // Byte address
    input wire logic [7:0]  wdata,              // Write data
    input wire logic        wr,                 // Write strobe
    input wire logic        rd,                 // Read strobe
    input wire logic        count_tick,         // Clock source active
    input wire logic [7:0]  rdata,              // Read data
    input wire logic [15:0] count_value,        // Live count
    input wire logic [15:0] reload_value,       // Active reload
    input wire logic [7:0]  timer_control_one,  // Control one
    input wire logic [31:0] channel_control     // Channel controls
);
    // ****************************************************************
    // Shadow of the subaddress and of the low byte latch
    // ****************************************************************
    logic [7:0] sub_q;
    logic [7:0] latch_q;
    logic [1:0] idx_q;
    logic       en;
    logic       cnt_wr;
    assign en = timer_control_one[mct_pkg::CTL1_RUN_ENABLE];
    assign cnt_wr = wr && (addr == mct_pkg::ADDR_COUNT_HIGH
                    || addr == mct_pkg::ADDR_COUNT_LOW);
    always_ff @(posedge clk) begin
        if (rst) begin
            sub_q <= 8'h00;
            latch_q <= 8'h00;
            idx_q <= 2'h0;
        end else begin
            if (wr && addr == mct_pkg::ADDR_SUBADDRESS)
                sub_q <= wdata;
            if (rd && addr == mct_pkg::ADDR_COUNT_HIGH && en)
                latch_q <= count_value[7:0];
            if (wr && addr == mct_pkg::ADDR_PORT_TWO)
                idx_q <= sub_q[1:0] - 2'h2;
        end
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_high_read;
        rd && addr == mct_pkg::ADDR_COUNT_HIGH;
    endsequence
    sequence s_low_read_en;
        rd && addr == mct_pkg::ADDR_COUNT_LOW && en;
    endsequence
    sequence s_reserved_read;
        rd && ((addr == mct_pkg::ADDR_PORT_TWO && sub_q[2:0] < 3'h2)
        || (addr >= mct_pkg::ADDR_PORT_ZERO && addr <= mct_pkg::ADDR_PORT_TWO
        && sub_q[2:0] > 3'h5));
    endsequence
    a_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_unmapped_read: assert property (
        rd && (addr < mct_pkg::ADDR_COUNT_HIGH
        || addr > mct_pkg::ADDR_PORT_TWO) |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_count_high_read: assert property (s_high_read
        |=> rdata == $past(count_value[15:8]))
        else $error("count high read wrong");
    a_low_read_live: assert property (
        rd && addr == mct_pkg::ADDR_COUNT_LOW
        && !en |=> rdata == $past(count_value[7:0]))
        else $error("disabled low read not live");
    a_low_read_latch: assert property (
        s_low_read_en |=> rdata == latch_q)
        else $error("enabled low read not latched");
    a_count_low_write: assert property (
        wr && addr == mct_pkg::ADDR_COUNT_LOW
        |=> count_value[7:0] == $past(wdata))
        else $error("count low write not loaded");
    a_count_hold: assert property ((!en || !count_tick) && !cnt_wr
        |=> $stable(count_value))
        else $error("count moved while idle");
    a_reload_high_held: assert property (wr && !en
        && addr == mct_pkg::ADDR_RELOAD_HIGH |=> $stable(reload_value))
        else $error("reload high applied alone");
    a_port_reserved: assert property (
        s_reserved_read |=> rdata == 8'h00)
        else $error("reserved subaddress read not zero");
    a_chan_ctl_write: assert property (
        wr && addr == mct_pkg::ADDR_PORT_TWO
        && sub_q[2:0] inside {[3'h2:3'h5]}
        |=> channel_control[8*idx_q +: 8] == $past(wdata))
        else $error("channel control write lost");
endmodule
bind multichannel_timer_reg_access reg_access_monitor mon (
    .clk, .rst, .addr, .wdata, .wr, .rd, .count_tick, .rdata,
    .count_value, .reload_value, .timer_control_one, .channel_control);
`default_nettype wire

// *** multichannel_timer_reg_access_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module multichannel_timer_reg_access_tb;
    localparam logic [11:0] SA = mct_pkg::ADDR_SUBADDRESS;
    localparam logic [11:0] P0 = mct_pkg::ADDR_PORT_ZERO;
    localparam logic [11:0] P1 = mct_pkg::ADDR_PORT_ONE;
    localparam logic [11:0] P2 = mct_pkg::ADDR_PORT_TWO;
    logic        clk, rst, wr, rd, count_tick, cycle_end;
    logic [11:0] addr;
    logic [7:0]  wdata, rdata, ctl0, ctl1, d;
    logic [3:0]  channel_event;
    logic [15:0] count_value, reload_value;
    logic [31:0] channel_control;
    logic [63:0] compare_value;
    int          error_cnt, checks_done;
    multichannel_timer_reg_access uut (.clk(clk), .rst(rst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .count_tick(count_tick),
        .channel_event(channel_event), .rdata(rdata),
        .count_value(count_value), .reload_value(reload_value),
        .timer_control_zero(ctl0), .timer_control_one(ctl1),
        .channel_control(channel_control), .compare_value(compare_value),
        .cycle_end(cycle_end));
    always #5 clk = ~clk;
    // ****************************************************************
    // Bus and checking tasks
    // ****************************************************************
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task wr_reg(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [11:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task ind_wr(input logic [2:0] s, input logic [11:0] p,
                input logic [7:0] v);
        wr_reg(SA, {5'h00, s});
        wr_reg(p, v);
    endtask
    task ind_rd(input logic [2:0] s, input logic [11:0] p,
                output logic [7:0] v);
        wr_reg(SA, {5'h00, s});
        rd_reg(p, v);
    endtask
    task idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task conclude;
        if (error_cnt == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset;
        check(count_value, 16'h0000);
        check(reload_value, 16'hFFFF);
        rd_reg(mct_pkg::ADDR_COUNT_LOW, d);
        check(d, 16'h0000);
        rd_reg(12'hFA8, d);
        check(d, 16'h0000);
        wr_reg(SA, 8'hF9);
        rd_reg(SA, d);
        check(d, 16'h00F9);
    endtask
    task t_map;
        for (int s = 2; s <= 5; s++) begin
            ind_wr(3'(s), P0, 8'h10 + 8'(s));
            ind_wr(3'(s), P1, 8'h20 + 8'(s));
            ind_wr(3'(s), P2, 8'h01 + 8'(s));
        end
        for (int s = 2; s <= 5; s++) begin
            ind_rd(3'(s), P0, d);
            check(d, 8'h10 + 8'(s));
            ind_rd(3'(s), P1, d);
            check(d, 8'h20 + 8'(s));
            ind_rd(3'(s), P2, d);
            check(d, 8'h01 + 8'(s));
            check(compare_value[16*(s-2) +: 16],
                  {8'h10 + 8'(s), 8'h20 + 8'(s)});
            check(channel_control[8*(s-2) +: 8], 8'h01 + 8'(s));
        end
        ind_wr(3'h0, P0, 8'hFF);
        ind_rd(3'h0, P0, d);
        check(d, 16'h0027);
        ind_wr(3'h1, P0, 8'h5A);
        ind_rd(3'h1, P0, d);
        check(d, 16'h005A);
        ind_wr(3'h0, P2, 8'hFF);
        ind_rd(3'h0, P2, d);
        check(d, 16'h0000);
        ind_rd(3'h6, P1, d);
        check(d, 16'h0000);
    endtask
    task t_latch;
        wr_reg(mct_pkg::ADDR_COUNT_HIGH, 8'h12);
        wr_reg(mct_pkg::ADDR_COUNT_LOW, 8'hFE);
        ind_wr(3'h0, P1, 8'h80);
        rd_reg(mct_pkg::ADDR_COUNT_HIGH, d);
        check(d, 16'h0012);
        check(count_value, 16'h12FE);
        @(posedge clk);
        count_tick <= 1'b1;
        repeat (3) @(posedge clk);
        count_tick <= 1'b0;
        rd_reg(mct_pkg::ADDR_COUNT_LOW, d);
        check(d, 16'h00FE);
        check(count_value, 16'h1301);
        ind_wr(3'h0, P1, 8'h00);
        idle(2);
        check(count_value, 16'h1301);
        rd_reg(mct_pkg::ADDR_COUNT_LOW, d);
        check(d, 16'h0001);
    endtask
    task t_run_write;
        ind_wr(3'h0, P1, 8'h80);
        count_tick <= 1'b1;
        wr_reg(mct_pkg::ADDR_COUNT_LOW, 8'h40);
        #1 check(count_value, 16'h1340);
        idle(3);
        check(count_value, 16'h1343);
        @(posedge clk);
        count_tick <= 1'b0;
    endtask
    task t_immediate;
        ind_wr(3'h2, P2, 8'h20);
        ind_wr(3'h2, P0, 8'hAB);
        ind_wr(3'h2, P1, 8'hCD);
        idle(2);
        check(compare_value[15:0], 16'hABCD);
        ind_wr(3'h3, P0, 8'h77);
        ind_wr(3'h3, P1, 8'h66);
        idle(2);
        check(compare_value[31:16], 16'h1323);
        ind_rd(3'h3, P0, d);
        check(d, 16'h0077);
        ind_wr(3'h0, P1, 8'h00);
        idle(3);
        check(compare_value[31:16], 16'h7766);
    endtask
    task t_reload;
        wr_reg(mct_pkg::ADDR_RELOAD_HIGH, 8'h12);
        idle(2);
        check(reload_value, 16'hFFFF);
        wr_reg(mct_pkg::ADDR_RELOAD_LOW, 8'h34);
        idle(2);
        check(reload_value, 16'h1234);
    endtask
    task t_interval;
        wr_reg(mct_pkg::ADDR_RELOAD_HIGH, 8'hFF);
        wr_reg(mct_pkg::ADDR_RELOAD_LOW, 8'hFF);
        ind_wr(3'h5, P2, 8'h20);
        ind_wr(3'h0, P1, 8'h80);
        ind_rd(3'h5, P0, d);
        check(d, 16'h0015);
        check(ctl1, 16'h0080);
        ind_wr(3'h5, P0, d + 8'h01);
        idle(2);
        check(compare_value[63:48], 16'h1625);
        @(posedge clk);
        channel_event <= 4'h8;
        @(posedge clk);
        channel_event <= 4'h0;
        ind_rd(3'h1, P1, d);
        check(d, 16'h0008);
        check(ctl0, 16'h0067);
        ind_wr(3'h1, P1, 8'h08);
        ind_rd(3'h1, P1, d);
        check(d, 16'h0000);
        ind_wr(3'h0, P1, 8'h00);
    endtask
    task t_cycle(input logic [7:0] mode, input int span);
        wr_reg(mct_pkg::ADDR_RELOAD_HIGH, 8'h00);
        wr_reg(mct_pkg::ADDR_RELOAD_LOW, 8'h02);
        wr_reg(mct_pkg::ADDR_COUNT_HIGH, 8'h00);
        wr_reg(mct_pkg::ADDR_COUNT_LOW, 8'h00);
        ind_wr(3'h0, P1, mode);
        count_tick <= 1'b1;
        repeat (span - 1) @(posedge clk);
        #1 check(cycle_end, 16'h0000);
        @(posedge clk);
        #1 check(cycle_end, 16'h0001);
        check(count_value, 16'h0000);
        @(posedge clk);
        count_tick <= 1'b0;
        ind_rd(3'h0, P0, d);
        check(d, 16'h00A7);
        ind_wr(3'h0, P0, 8'hA7);
        ind_rd(3'h0, P0, d);
        check(d, 16'h0027);
        ind_wr(3'h0, P1, 8'h00);
    endtask
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        addr = 12'h000;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        count_tick = 1'b0;
        channel_event = 4'h0;
        error_cnt = 0;
        checks_done = 0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        idle(1);
        t_reset;
        t_map;
        t_latch;
        t_run_write;
        t_immediate;
        t_reload;
        t_interval;
        t_cycle(8'h80, 3);
        t_cycle(8'hA0, 4);
        conclude;
    end
    initial begin
        #200000;
        error_cnt++;
        conclude;
    end
endmodule
`default_nettype wire
